// *** src/ulr_buf2.sv ***
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes fill and drain sit on the same clock; ce_i freezes it.
 */
`timescale 1ns/1ps
`default_nettype none
module ulr_buf2 #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// Drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	logic [W-1:0] mem_q [2];
	logic wp_q;
	logic rp_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic push;
	logic pop;

	assign push = ce_i && in_valid_i && in_ready_o;
	assign pop = ce_i && out_ready_i && out_valid_o;
	assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});
	assign out_valid_o = cnt_q != 2'h0;
	assign out_data_o = mem_q[rp_q];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wp_q] <= in_data_i;
		end
	end

	// Ready is registered so a full buffer never takes a third word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= 1'b0;
			rp_q <= 1'b0;
			cnt_q <= 2'h0;
			in_ready_o <= 1'b0;
		end else if (ce_i) begin
			wp_q <= wp_q ^ push;
			rp_q <= rp_q ^ pop;
			cnt_q <= cnt_d;
			in_ready_o <= cnt_d != 2'h2;
		end
	end
endmodule
`default_nettype wire

// *** src/ulr_pkg.sv ***
/*
 * Constants, state codes and the configuration carrier for the
 * uplink random-access timing and marker generator.
 * Assumes a 100 MHz reference clock and a 3.84 MHz default chip rate.
 */
// Notes on behaviour
// - Message data raw output carries data-part bits before spreading and scrambling.
// - Message control raw output carries control-part bits before spreading and scrambling.
// - A dedicated clock output paces the message data raw bits.
// - A separate clock output paces the message control raw bits.
// - Processing level stays high from start until all repetitions are done.
// - Processing level reads 1 while generating and 0 while off.
// - Processing level changes only on access slot boundaries.
// - Sub-channel pulses as configured; every random-access stream starts on one.
// - The 10 ms frame pulse marks every frame number boundary.
// - The 80 ms frame pulse marks only frames whose number modulo eight is zero.
// - The preamble pulse marks the start of every preamble access slot.
// - The message pulse marks an access slot only when a message is sent there.
// - The repetition pulse marks the first access slot of each repetition.
// - All markers are timed on the chip clock, which is driven out.
// - Dedicated mode delays frame timing by 1024 chips plus timing and slot offsets.
// - Frame numbering aligns to the external frame sync trigger.
// - The chip clock runs at 3.84 MHz unless another rate is set.
package ulr_pkg;

	// ********************************
	// Clock and frame timing
	// ********************************
	localparam int REF_CLK_HZ = 100_000_000;
	localparam int CHIP_RATE_HZ = 3_840_000;
	localparam int NCO_MOD_INT = 10000;
	localparam logic [13:0] NCO_MOD = 14'(NCO_MOD_INT);
	localparam logic [13:0] NCO_HALF = 14'(NCO_MOD_INT / 2);
	localparam logic [13:0] CHIP_STEP_DEF = 14'(CHIP_RATE_HZ / (REF_CLK_HZ / NCO_MOD_INT));
	localparam int FRAME_MS = 10;
	localparam int SLOTS_PER_FRAME = 15;
	localparam int CHIPS_PER_FRAME = CHIP_RATE_HZ / 1000 * FRAME_MS;
	localparam int CHIPS_PER_SLOT = CHIPS_PER_FRAME / SLOTS_PER_FRAME;
	localparam logic [11:0] CHIP_MAX = 12'(CHIPS_PER_SLOT - 1);
	localparam logic [3:0] SLOT_MAX = 4'(SLOTS_PER_FRAME - 1);
	localparam logic [3:0] SUBCH_MAX = 4'hB;
	localparam logic [16:0] T0_CHIPS = 17'h00400;
	localparam logic [8:0] CTRL_SF = 9'h100;
	localparam logic [2:0] SFN80_MASK = 3'h7;

	// ********************************
	// Reset values
	// ********************************
	localparam logic [11:0] SFN_RST = 12'h000;
	localparam logic [13:0] ACC_RST = 14'h0000;

	// ********************************
	// Types
	// ********************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ARMED = 4'h2,
		ST_PRE = 4'h4,
		ST_MSG = 4'h8
	} ulr_state_e;

	typedef struct packed {
		logic [13:0] chip_step;
		logic [3:0] sf_log2;
		logic [15:0] timing_ofs;
		logic [3:0] slot_ofs;
		logic [7:0] reps;
		logic [3:0] preambles;
		logic [3:0] msg_slots;
		logic [11:0] subch_mask;
		logic msg_en;
		logic dpch_mode;
		logic sync_sfn;
		logic [2:0] period_sel;
		logic cont;
	} ulr_cfg_s;

	// Frame-clock period in frames, minus one, as a rounding mask
	function automatic logic [11:0] ulr_period_mask(input logic [2:0] sel);
		case (sel)
			3'h0: ulr_period_mask = 12'h000;
			3'h1: ulr_period_mask = 12'h001;
			3'h2: ulr_period_mask = 12'h003;
			3'h3: ulr_period_mask = 12'h007;
			default: ulr_period_mask = 12'h0FF;
		endcase
	endfunction

endpackage

// *** src/ulr_timing.sv ***
/*
 * Uplink random-access timing and marker generator: chip clock,
 * frame and slot counters aligned to an external sync trigger,
 * access-slot sequencer and two raw bit streams with their clocks.
 * Assumes config and raw bits come from logic on ref_clk_i and that
 * the sync trigger is an asynchronous pin.
 */
`timescale 1ns/1ps
`default_nettype none
module ulr_timing
	import ulr_pkg::*;
(
	// Clock, reset, enable
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Configuration and start
	input wire ulr_cfg_s cfg_i,
	input wire logic start_i,
	// Sync pin
	input wire logic frame_sync_trigger_in_i,
	// Raw bit sources, index 0 data part, 1 control part
	input wire logic [1:0] raw_valid_i,
	input wire logic [1:0] raw_bit_i,
	output logic [1:0] raw_ready_o,
	// Chip clock
	output logic chip_clock_select_o,
	// Raw streams
	output logic message_data_raw_out_o,
	output logic message_data_raw_clk_o,
	output logic message_ctrl_raw_out_o,
	output logic message_ctrl_raw_clk_o,
	// Markers
	output logic access_processing_level_o,
	output logic subchannel_timing_pulse_o,
	output logic frame10_pulse_o,
	output logic frame80_pulse_o,
	output logic preamble_slot_pulse_o,
	output logic message_slot_pulse_o,
	output logic repetition_start_pulse_o
);

	// ********************************
	// Chip clock
	// ********************************
	logic [13:0] acc_q;
	logic [14:0] acc_sum;
	logic [13:0] acc_d;
	logic [13:0] step;
	logic tick_w;

	assign step = (cfg_i.chip_step == 14'h0000) ? CHIP_STEP_DEF : cfg_i.chip_step;
	assign acc_sum = {1'b0, acc_q} + {1'b0, step};
	assign acc_d = (acc_sum >= {1'b0, NCO_MOD}) ? 14'(acc_sum - {1'b0, NCO_MOD}) : acc_sum[13:0];
	assign tick_w = ce_i && (acc_sum >= {1'b0, NCO_MOD});

	// Fractional divider: edges jitter by one reference period
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			acc_q <= ACC_RST;
			chip_clock_select_o <= 1'b0;
		end else if (ce_i) begin
			acc_q <= acc_d;
			chip_clock_select_o <= acc_d < NCO_HALF;
		end
	end

	// ********************************
	// Sync trigger input
	// ********************************
	logic sy1_q;
	logic sy2_q;
	logic sy3_q;
	logic used_q;
	logic dly_run_q;
	logic [16:0] dly_q;
	logic [16:0] dly_ld;
	logic trig_w;
	logic align_w;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sy1_q <= 1'b0;
			sy2_q <= 1'b0;
			sy3_q <= 1'b0;
		end else if (ce_i) begin
			sy1_q <= frame_sync_trigger_in_i;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	// Single mode uses only the first trigger after reset
	assign trig_w = ce_i && sy2_q && !sy3_q && (cfg_i.cont || !used_q);
	assign dly_ld = 17'({1'b0, cfg_i.timing_ofs} + 17'(cfg_i.slot_ofs) * 17'(CHIPS_PER_SLOT)
		+ (cfg_i.dpch_mode ? T0_CHIPS : 17'h00000));
	assign align_w = tick_w && dly_run_q && (dly_q == 17'h00000);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			used_q <= 1'b0;
			dly_run_q <= 1'b0;
			dly_q <= 17'h00000;
		end else if (trig_w) begin
			used_q <= 1'b1;
			dly_run_q <= 1'b1;
			dly_q <= dly_ld;
		end else if (align_w) begin
			dly_run_q <= 1'b0;
		end else if (tick_w && dly_run_q) begin
			dly_q <= 17'(dly_q - 17'h00001);
		end
	end

	// ********************************
	// Frame, slot and access slot counters
	// ********************************
	logic [11:0] chip_q;
	logic [11:0] chip_d;
	logic [3:0] slot_q;
	logic [3:0] slot_d;
	logic [11:0] sfn_q;
	logic [11:0] sfn_d;
	logic [11:0] pmask;
	logic [11:0] sfn_inc;
	logic half_q;
	logic half_d;
	logic [3:0] subi_q;
	logic [3:0] subi_d;
	logic sof_w;
	logic sos_w;
	logic as_bnd_w;
	logic as_evt;
	logic sub_hit_w;

	assign pmask = ulr_period_mask(cfg_i.period_sel);
	assign sfn_inc = 12'(sfn_q + 12'h001);

	always_comb begin
		chip_d = 12'(chip_q + 12'h001);
		slot_d = slot_q;
		sfn_d = sfn_q;
		half_d = half_q;
		subi_d = subi_q;
		sof_w = 1'b0;
		sos_w = 1'b0;
		if (align_w) begin
			chip_d = 12'h000;
			slot_d = 4'h0;
			sfn_d = cfg_i.sync_sfn ? SFN_RST : (12'(sfn_inc + pmask) & ~pmask);
			half_d = 1'b0;
			subi_d = 4'h0;
			sof_w = 1'b1;
			sos_w = 1'b1;
		end else if (chip_q == CHIP_MAX) begin
			chip_d = 12'h000;
			sos_w = 1'b1;
			half_d = ~half_q;
			if (slot_q == SLOT_MAX) begin
				slot_d = 4'h0;
				sfn_d = sfn_inc;
				sof_w = 1'b1;
			end else begin
				slot_d = 4'(slot_q + 4'h1);
			end
			if (half_q) begin
				subi_d = (subi_q == SUBCH_MAX) ? 4'h0 : 4'(subi_q + 4'h1);
			end
		end
	end

	assign as_bnd_w = sos_w && !half_d;
	assign as_evt = tick_w && as_bnd_w;
	assign sub_hit_w = as_bnd_w && cfg_i.subch_mask[subi_d];

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			chip_q <= 12'h000;
			slot_q <= 4'h0;
			sfn_q <= SFN_RST;
			half_q <= 1'b0;
			subi_q <= 4'h0;
		end else if (tick_w) begin
			chip_q <= chip_d;
			slot_q <= slot_d;
			sfn_q <= sfn_d;
			half_q <= half_d;
			subi_q <= subi_d;
		end
	end

	// Markers last one chip so a chip-clocked receiver sees them
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			frame10_pulse_o <= 1'b0;
			frame80_pulse_o <= 1'b0;
			subchannel_timing_pulse_o <= 1'b0;
		end else if (tick_w) begin
			frame10_pulse_o <= sof_w;
			frame80_pulse_o <= sof_w && ((sfn_d[2:0] & SFN80_MASK) == 3'h0);
			subchannel_timing_pulse_o <= sub_hit_w;
		end
	end

	// ********************************
	// Access slot sequencer
	// ********************************
	ulr_state_e st_q;
	ulr_state_e st_d;
	logic pend_q;
	logic [3:0] pre_cnt_q;
	logic [3:0] msg_cnt_q;
	logic [7:0] rep_cnt_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
		end else if (ce_i && start_i) begin
			pend_q <= 1'b1;
		end else if (as_evt && st_q == ST_IDLE) begin
			pend_q <= 1'b0;
		end
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (as_evt && pend_q && cfg_i.reps != 8'h00) begin
					st_d = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (tick_w && sub_hit_w) begin
					st_d = ST_PRE;
				end
			end
			ST_PRE: begin
				if (as_evt && pre_cnt_q == 4'h0) begin
					if (cfg_i.msg_en) begin
						st_d = ST_MSG;
					end else begin
						st_d = (rep_cnt_q == 8'h00) ? ST_IDLE : ST_ARMED;
					end
				end
			end
			ST_MSG: begin
				if (as_evt && msg_cnt_q == 4'h0) begin
					st_d = (rep_cnt_q == 8'h00) ? ST_IDLE : ST_ARMED;
				end
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_q <= ST_IDLE;
			pre_cnt_q <= 4'h0;
			msg_cnt_q <= 4'h0;
			rep_cnt_q <= 8'h00;
		end else if (tick_w) begin
			st_q <= st_d;
			if (st_q == ST_IDLE && st_d == ST_ARMED) begin
				rep_cnt_q <= 8'(cfg_i.reps - 8'h01);
			end else if (st_q != ST_ARMED && st_d == ST_ARMED) begin
				rep_cnt_q <= 8'(rep_cnt_q - 8'h01);
			end
			if (st_d == ST_PRE && st_q != ST_PRE) begin
				pre_cnt_q <= (cfg_i.preambles == 4'h0) ? 4'h0 : 4'(cfg_i.preambles - 4'h1);
			end else if (as_evt && pre_cnt_q != 4'h0) begin
				pre_cnt_q <= 4'(pre_cnt_q - 4'h1);
			end
			if (st_d == ST_MSG && st_q != ST_MSG) begin
				msg_cnt_q <= (cfg_i.msg_slots == 4'h0) ? 4'h0 : 4'(cfg_i.msg_slots - 4'h1);
			end else if (as_evt && msg_cnt_q != 4'h0) begin
				msg_cnt_q <= 4'(msg_cnt_q - 4'h1);
			end
		end
	end

	// Level and slot markers move only with the sequencer, on boundaries
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			access_processing_level_o <= 1'b0;
			preamble_slot_pulse_o <= 1'b0;
			message_slot_pulse_o <= 1'b0;
			repetition_start_pulse_o <= 1'b0;
		end else if (tick_w) begin
			access_processing_level_o <= st_d != ST_IDLE;
			preamble_slot_pulse_o <= as_bnd_w && st_d == ST_PRE;
			message_slot_pulse_o <= st_q == ST_PRE && st_d == ST_MSG;
			repetition_start_pulse_o <= st_q == ST_ARMED && st_d == ST_PRE;
		end
	end

	// ********************************
	// Raw bit streams
	// ********************************
	logic [1:0] raw_bit_q;
	logic [1:0] raw_clk_q;

	generate
		for (genvar i = 0; i < 2; i++) begin : g_lane
			logic [8:0] per;
			logic [8:0] ph_q;
			logic go_w;
			logic bv;
			logic bd;

			assign per = (i == 0) ? 9'(9'h001 << cfg_i.sf_log2) : CTRL_SF;
			// Bit periods restart at the message slot boundary
			assign go_w = tick_w && st_d == ST_MSG && (st_q != ST_MSG || ph_q == 9'(per - 9'h001));

			ulr_buf2 #(
				.W(1)
			) u_buf (
				.clk_i(ref_clk_i),
				.rst_i(rst_i),
				.ce_i(ce_i),
				.in_valid_i(raw_valid_i[i]),
				.in_data_i(raw_bit_i[i]),
				.in_ready_o(raw_ready_o[i]),
				.out_valid_o(bv),
				.out_data_o(bd),
				.out_ready_i(go_w)
			);

			// Underrun sends zero rather than stalling the air timing
			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					ph_q <= 9'h000;
					raw_bit_q[i] <= 1'b0;
					raw_clk_q[i] <= 1'b0;
				end else if (go_w) begin
					ph_q <= 9'h000;
					raw_bit_q[i] <= bv && bd;
					raw_clk_q[i] <= 1'b1;
				end else if (tick_w) begin
					ph_q <= 9'(ph_q + 9'h001);
					if (st_d != ST_MSG || 9'(ph_q + 9'h001) == (per >> 1)) begin
						raw_clk_q[i] <= 1'b0;
					end
				end
			end

			property p_raw_edge;
				@(posedge ref_clk_i) disable iff (rst_i)
				$changed(raw_bit_q[i]) |-> $rose(raw_clk_q[i]);
			endproperty
			a_raw_edge: assert property (p_raw_edge)
				else $error("raw bit changed off the rising raw clock");
		end
	endgenerate

	assign message_data_raw_out_o = raw_bit_q[0];
	assign message_data_raw_clk_o = raw_clk_q[0];
	assign message_ctrl_raw_out_o = raw_bit_q[1];
	assign message_ctrl_raw_clk_o = raw_clk_q[1];

	// ********************************
	// Checks
	// ********************************
	property p_proc_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		(st_q == ST_PRE || st_q == ST_MSG) |-> access_processing_level_o;
	endproperty
	a_proc_hold: assert property (p_proc_hold)
		else $error("processing level low during a repetition");

	property p_proc_off;
		@(posedge ref_clk_i) disable iff (rst_i)
		(st_q == ST_IDLE) |-> !access_processing_level_o;
	endproperty
	a_proc_off: assert property (p_proc_off)
		else $error("processing level high while idle");

	property p_proc_slot;
		@(posedge ref_clk_i) disable iff (rst_i)
		$changed(access_processing_level_o) |-> $past(as_evt);
	endproperty
	a_proc_slot: assert property (p_proc_slot)
		else $error("processing level moved off an access slot boundary");

	property p_rep_sub;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(repetition_start_pulse_o) |-> subchannel_timing_pulse_o;
	endproperty
	a_rep_sub: assert property (p_rep_sub)
		else $error("repetition began without a sub-channel pulse");

	property p_f10;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(frame10_pulse_o) |-> $past(tick_w && sof_w) && chip_q == 12'h000 && slot_q == 4'h0;
	endproperty
	a_f10: assert property (p_f10)
		else $error("frame pulse away from a frame boundary");

	property p_f80;
		@(posedge ref_clk_i) disable iff (rst_i)
		frame80_pulse_o |-> frame10_pulse_o && sfn_q[2:0] == 3'h0;
	endproperty
	a_f80: assert property (p_f80)
		else $error("80 ms pulse on a frame not divisible by eight");

	property p_pre;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(preamble_slot_pulse_o) |-> st_q == ST_PRE && chip_q == 12'h000 && !half_q;
	endproperty
	a_pre: assert property (p_pre)
		else $error("preamble pulse outside a preamble access slot start");

	property p_msg;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(message_slot_pulse_o) |-> st_q == ST_MSG && !preamble_slot_pulse_o;
	endproperty
	a_msg: assert property (p_msg)
		else $error("message pulse without a message slot");

	property p_rep;
		@(posedge ref_clk_i) disable iff (rst_i)
		$rose(repetition_start_pulse_o) |-> preamble_slot_pulse_o && access_processing_level_o;
	endproperty
	a_rep: assert property (p_rep)
		else $error("repetition pulse not on a first preamble slot");

	property p_align;
		@(posedge ref_clk_i) disable iff (rst_i)
		align_w |=> frame10_pulse_o && chip_q == 12'h000 && dly_run_q == $past(trig_w);
	endproperty
	a_align: assert property (p_align)
		else $error("alignment did not restart the frame");
endmodule
`default_nettype wire

// *** test/testbench.sv ***
/*
 * Self-checking bench for ulr_timing: sync alignment, one access
 * sequence with raw lanes, frame markers. Assumes ulr_bs_model.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ulr_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int CPC = NCO_MOD_INT / 5000;
	localparam int AS = 2 * CHIPS_PER_SLOT * CPC;
	logic ref_clk_i = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic src_en = 1'b0;
	logic pin, chipck, dout, dclk, cout, cclk, lvl, sub, f10, f80, pre, msg, rep;
	logic [1:0] rvalid = 2'h0;
	logic [1:0] rbit = 2'h0;
	logic [1:0] rdy;
	logic [1:0] rdy_low;
	logic [1:0] fire;
	ulr_cfg_s cfg;
	int cyc, n_errors, total_checks, t_trig, t_f10, t_f10p, n_f10, n_f80, bad_f80, n_pre, n_msg, n_rep;
	int t_msg, t_fall, bad_lvl, n_dclk, n_dclk_pre, n_db, n_cb, n_ck, ck_frame;
	int t_pre[4];
	int n_push[2];
	logic f80_at_f10, rep_ok, pin_q, f10_q, f80_q, pre_q, msg_q, rep_q, lvl_q, dclk_q, cclk_q, ck_q;
	logic [11:0] dbits, cbits;
	localparam logic [7:0] DPAT = 8'h4D;
	localparam logic [3:0] CPAT = 4'h5;
	always #5 ref_clk_i = ~ref_clk_i;
	ulr_bs_model i_ulr_bs_model (.ref_clk_i(ref_clk_i), .frame_sync_trigger_in_o(pin));
	ulr_timing i_ulr_timing (.ref_clk_i(ref_clk_i), .rst_i(rst), .ce_i(1'b1), .cfg_i(cfg), .start_i(start),
		.frame_sync_trigger_in_i(pin), .raw_valid_i(rvalid), .raw_bit_i(rbit), .raw_ready_o(rdy),
		.chip_clock_select_o(chipck), .message_data_raw_out_o(dout), .message_data_raw_clk_o(dclk),
		.message_ctrl_raw_out_o(cout), .message_ctrl_raw_clk_o(cclk), .access_processing_level_o(lvl),
		.subchannel_timing_pulse_o(sub), .frame10_pulse_o(f10), .frame80_pulse_o(f80),
		.preamble_slot_pulse_o(pre), .message_slot_pulse_o(msg), .repetition_start_pulse_o(rep));
	// ****************************************
	// Monitor and raw bit source
	// ****************************************
	// Samples on the falling edge, where registered outputs have settled
	always @(negedge ref_clk_i) begin
		cyc++;
		if (!rst) begin
			if (pin && !pin_q) t_trig = cyc;
			if (chipck && !ck_q) n_ck++;
			if (f10 && !f10_q) begin
				n_f10++;
				t_f10p = t_f10;
				t_f10 = cyc;
				f80_at_f10 = f80;
				ck_frame = n_ck;
				n_ck = 0;
			end
			if (f80 && !f80_q) begin
				n_f80++;
				if (!f10) bad_f80++;
			end
			if (pre && !pre_q) begin
				if (n_pre < 4) t_pre[n_pre] = cyc;
				n_pre++;
				if (!lvl) bad_lvl++;
			end
			if (msg && !msg_q) begin
				n_msg++;
				t_msg = cyc;
				n_dclk_pre = n_dclk;
				if (!lvl) bad_lvl++;
			end
			if (rep && !rep_q) begin
				n_rep++;
				rep_ok = pre && sub;
			end
			if (lvl !== lvl_q) begin
				if (!sub) bad_lvl++;
				if (!lvl) t_fall = cyc;
			end
			if (dclk && !dclk_q) n_dclk++;
			// Falling raw clock edge is where an outside sampler captures
			if (!dclk && dclk_q && n_db < 12) dbits[n_db++] = dout;
			if (!cclk && cclk_q && n_cb < 12) cbits[n_cb++] = cout;
			if (src_en) rdy_low = rdy_low | ~rdy;
		end
		{pin_q, f10_q, f80_q, pre_q, msg_q, rep_q, lvl_q, dclk_q, cclk_q, ck_q} =
			{pin, f10, f80, pre, msg, rep, lvl, dclk, cclk, chipck};
	end
	// Source stops after a few bits so the lanes later run dry
	// Handshake taken mid-cycle, before ready can move at the rising edge
	always begin
		@(negedge ref_clk_i);
		fire = rvalid & rdy;
		@(posedge ref_clk_i);
		for (int k = 0; k < 2; k++) if (fire[k]) n_push[k]++;
		#1;
		rvalid = {src_en && n_push[1] < 3, src_en && n_push[0] < 8};
		rbit = {CPAT[n_push[1][1:0]], DPAT[n_push[0][2:0]]};
	end
	// ****************************************
	// Checking helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tmo(input logic ok);
		if (!ok) begin
			n_errors++;
			$display("wrong value at %0t: wait ran out", $time);
			tally_and_finish();
		end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		chk({lvl, sub, f10, f80, pre, msg, rep, dclk, cclk}, 32'h0);
		$display("test reset done");
	endtask
	// Delay from trigger differs by the fixed 1024 chips between modes
	task automatic t_sync(input logic dpch, input logic single);
		int i, exp, gap;
		@(posedge ref_clk_i);
		#1 rst = 1'b1;
		repeat (2) @(posedge ref_clk_i);
		#1 cfg.dpch_mode = dpch;
		cfg.cont = !single;
		cfg.sync_sfn = !single;
		cfg.period_sel = single ? 3'h3 : 3'h0;
		rst = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		n_f10 = 0;
		n_f80 = 0;
		i_ulr_bs_model.send_trigger(4);
		for (i = 0; i < 4000 && n_f10 == 0; i++) @(posedge ref_clk_i);
		tmo(n_f10 != 0);
		#1 exp = CPC * (16 + (dpch ? 1024 : 0));
		gap = t_f10 - t_trig;
		chk(gap >= exp && gap <= exp + 12, 1'b1);
		chk(f80_at_f10, 1'b1);
		// Single mode must ignore every trigger after the first
		if (single) begin
			i_ulr_bs_model.send_trigger(4);
			repeat (100) @(posedge ref_clk_i);
			chk(n_f10, 1);
		end
		$display("test sync dpch=%0d single=%0d done", dpch, single);
	endtask
	task automatic t_sequence();
		int i;
		n_pre = 0;
		n_msg = 0;
		n_rep = 0;
		bad_lvl = 0;
		rdy_low = 2'h0;
		src_en = 1'b1;
		@(posedge ref_clk_i);
		#1 start = 1'b1;
		@(posedge ref_clk_i);
		#1 start = 1'b0;
		for (i = 0; i < 3 * AS && !lvl; i++) @(posedge ref_clk_i);
		tmo(lvl === 1'b1);
		for (i = 0; i < 7 * AS && lvl; i++) @(posedge ref_clk_i);
		tmo(lvl === 1'b0);
		repeat (2) @(posedge ref_clk_i);
		chk(n_pre, 2);
		chk(t_pre[1] - t_pre[0], AS);
		chk(n_msg, 1);
		chk(t_msg - t_pre[1], AS);
		chk(n_rep, 1);
		chk(rep_ok, 1'b1);
		chk(t_fall - t_msg, AS);
		chk(bad_lvl, 0);
		chk(n_dclk_pre, 0);
		chk(rdy_low, 2'h3);
		chk(dbits, {4'h0, DPAT});
		chk(cbits[5:0], {3'h0, CPAT[2:0]});
		$display("test sequence done");
	endtask
	task automatic t_next_frame();
		int i;
		for (i = 0; i < 80000 && n_f10 < 2; i++) @(posedge ref_clk_i);
		tmo(n_f10 >= 2);
		#1 chk(t_f10 - t_f10p, CPC * CHIPS_PER_FRAME);
		chk(ck_frame, CHIPS_PER_FRAME);
		chk(n_f80, 1);
		chk(bad_f80, 0);
		$display("test next frame done");
	endtask
	// Zero step selects the default chip rate; 10000 cycles span 100 us
	task automatic t_rate();
		int n0;
		#1 cfg.chip_step = 14'h0000;
		@(posedge ref_clk_i);
		#1 n0 = n_ck;
		repeat (10000) @(posedge ref_clk_i);
		#1 n0 = n_ck - n0;
		chk(n0 >= CHIP_RATE_HZ / 10000 - 1 && n0 <= CHIP_RATE_HZ / 10000 + 1, 1'b1);
		$display("test chip rate done");
	endtask
	initial begin
		cfg = '0;
		cfg.chip_step = 14'h1388;
		cfg.sf_log2 = 4'h1;
		cfg.timing_ofs = 16'h0010;
		cfg.reps = 8'h01;
		cfg.preambles = 4'h2;
		cfg.msg_slots = 4'h1;
		cfg.subch_mask = 12'hFFF;
		cfg.msg_en = 1'b1;
		cfg.sync_sfn = 1'b1;
		cfg.cont = 1'b1;
		repeat (10) @(posedge ref_clk_i);
		#1 t_reset();
		repeat (2) @(posedge ref_clk_i);
		#1 rst = 1'b0;
		t_sync(1'b1, 1'b0);
		t_sync(1'b0, 1'b1);
		t_sequence();
		t_next_frame();
		t_rate();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// *** test/ulr_bs_model.sv ***
/*
 * Base station model: drives the frame sync trigger pin.
 * Assumes the bench calls send_trigger just after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module ulr_bs_model (
	// Clock
	input wire logic ref_clk_i,
	// Sync pin
	output logic frame_sync_trigger_in_o
);
	// Idle low between triggers, nothing else drives the pin
	initial frame_sync_trigger_in_o = 1'b0;
	// Single frame-number reset pulse; no repeating frame clock, so no period to match
	task automatic send_trigger(input int width);
		@(posedge ref_clk_i);
		#1 frame_sync_trigger_in_o = 1'b1;
		repeat (width) @(posedge ref_clk_i);
		#1 frame_sync_trigger_in_o = 1'b0;
	endtask
endmodule
`default_nettype wire
